// *** rtl/ufs_regs.vh ***
// Register map, field positions and reset values of the UART level and flow-control block
`ifndef UFS_REGS_VH
`define UFS_REGS_VH
// Register addresses (word index on the plain register port)
`define UFS_A_RHR_THR 4'h0
`define UFS_A_IER 4'h1
`define UFS_A_ISR_FCR 4'h2
`define UFS_A_LCR 4'h3
`define UFS_A_MCR 4'h4
`define UFS_A_LSR 4'h5
`define UFS_A_MSR 4'h6
`define UFS_A_SPR 4'h7
`define UFS_A_FEATURE_CONTROL_REG 4'h8
`define UFS_A_EFR 4'h9
`define UFS_A_TX_FIFO_LEVEL_COUNT_TRG 4'ha
`define UFS_A_RX_FIFO_LEVEL_COUNT_TRG 4'hb
`define UFS_A_STOP_CHAR_FIRST 4'hc
`define UFS_A_STOP_CHAR_SECOND 4'hd
`define UFS_A_RESUME_CHAR_FIRST 4'he
`define UFS_A_RESUME_CHAR_SECOND_XCH 4'hf
`define UFS_A_DLL 4'h0
`define UFS_A_DLM 4'h1
`define UFS_A_DLD 4'h2
// Reset values
`define UFS_RST_ZERO 8'h00
`define UFS_RST_DLL 8'h01
`define UFS_RST_ISR 8'h01
`define UFS_RST_LSR 8'h60
`define UFS_RST_SPR 8'hff
// Field positions
`define UFS_LCR_DLAB 7
`define UFS_EFR_SWFC_HI 3
`define UFS_EFR_SWFC_LO 0
`define UFS_IER_RX 0
`define UFS_IER_TX 1
`define UFS_XCH_TXON 3
`define UFS_XCH_TXOFF 2
`define UFS_XCH_RXON 1
`define UFS_XCH_RXOFF 0
`define UFS_LSR_THRE 5
`define UFS_LSR_TEMT 6
`define UFS_LSR_DR 0
`define UFS_MCR_DTR 0
`define UFS_MCR_RTS 1
// Interrupt source codes in the status register
`define UFS_ISR_NONE 8'h01
`define UFS_ISR_RX_FIFO_TRIGGER_LEVEL 8'h04
`define UFS_ISR_TX_FIFO_TRIGGER_LEVEL 8'h02
// Count limits
`define UFS_CNT_MAX 8'hff
`define UFS_CNT_ONE 8'h01
`endif

// *** rtl/ufs_top.v ***
// UART channel register file: FIFO levels, triggers, flow-control characters and status
`timescale 1ns/1ps
`include "ufs_regs.vh"

module ufs_top
(
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Register port
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // FIFO side events from the datapath
  input wire tx_push_in,
  input wire tx_pop_in,
  input wire rx_push_in,
  input wire rx_pop_in,
  // Flow-control character events from the serial engine
  input wire sent_resume_in,
  input wire sent_stop_in,
  input wire got_resume_in,
  input wire got_stop_in,
  // Modem inputs (CTS, DSR, RI, CD levels)
  input wire [3:0] modem_lvl_in,
  // Serial engine pin requests
  input wire tx_serial_in,
  input wire infrared_tx_in,
  // Interrupt requests and configuration out
  output reg tx_irq_out,
  output reg rx_irq_out,
  output reg [7:0] stop_char_first_out,
  output reg [7:0] stop_char_second_out,
  output reg [7:0] resume_char_first_out,
  output reg [7:0] resume_char_second_out,
  output reg [7:0] divisor_out,
  output reg [7:0] divisor_high_out,
  output reg [7:0] divisor_fraction_out,
  // Pins
  output reg tx_out,
  output reg rts_b_out,
  output reg dtr_b_out,
  output reg infrared_tx_out,
  output reg eeprom_clock_out,
  output reg eeprom_select_out,
  output reg eeprom_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] ier_ff;
  reg [7:0] fcr_ff;
  reg [7:0] lcr_ff;
  reg [7:0] mcr_ff;
  reg [7:0] spr_ff;
  reg [7:0] feature_control_reg_ff;
  reg [7:0] efr_ff;
  reg [7:0] tx_fifo_level_count_ff;
  reg [7:0] rx_fifo_level_count_ff;
  reg [7:0] tx_fifo_trigger_level_ff;
  reg [7:0] rx_fifo_trigger_level_ff;
  reg [3:0] flow_char_status_ff;
  reg [3:0] msr_lo_ff;
  reg [3:0] modem_prev_ff;
  reg msr_armed_ff;

  wire dlab = lcr_ff[`UFS_LCR_DLAB];
  wire wr_hit_fcs;
  wire rd_fcs;
  wire swfc_off;
  wire [7:0] isr_val;
  wire [7:0] lsr_val;

  // Count update: saturating up/down; push and pop together leave it alone
  function [7:0] ufs_count;
    input [7:0] cnt;
    input up;
    input dn;
    begin
      if (up && !dn && cnt != `UFS_CNT_MAX)
        ufs_count = cnt + `UFS_CNT_ONE;
      else if (dn && !up && cnt != `UFS_RST_ZERO)
        ufs_count = cnt - `UFS_CNT_ONE;
      else
        ufs_count = cnt;
    end
  endfunction

  assign swfc_off = (efr_ff[`UFS_EFR_SWFC_HI:`UFS_EFR_SWFC_LO] == 4'h0);
  assign wr_hit_fcs = wr_in && !dlab;
  assign rd_fcs = rd_in && addr_in == `UFS_A_RESUME_CHAR_SECOND_XCH;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and write decode

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      ier_ff <= `UFS_RST_ZERO;
      fcr_ff <= `UFS_RST_ZERO;
      lcr_ff <= `UFS_RST_ZERO;
      mcr_ff <= `UFS_RST_ZERO;
      feature_control_reg_ff <= `UFS_RST_ZERO;
      efr_ff <= `UFS_RST_ZERO;
      spr_ff <= `UFS_RST_SPR;
      tx_fifo_trigger_level_ff <= `UFS_RST_ZERO;
      rx_fifo_trigger_level_ff <= `UFS_RST_ZERO;
      stop_char_first_out <= `UFS_RST_ZERO;
      stop_char_second_out <= `UFS_RST_ZERO;
      resume_char_first_out <= `UFS_RST_ZERO;
      resume_char_second_out <= `UFS_RST_ZERO;
      divisor_out <= `UFS_RST_DLL;
      divisor_high_out <= `UFS_RST_ZERO;
      divisor_fraction_out <= `UFS_RST_ZERO;
    end
    else if (wr_in)
    begin
      if (dlab && addr_in == `UFS_A_DLL)
        divisor_out <= wdata_in;
      if (dlab && addr_in == `UFS_A_DLM)
        divisor_high_out <= wdata_in;
      if (dlab && addr_in == `UFS_A_DLD)
        divisor_fraction_out <= wdata_in;
      if (addr_in == `UFS_A_LCR)
        lcr_ff <= wdata_in;
      if (wr_hit_fcs)
      begin
        case (addr_in)
          `UFS_A_IER: ier_ff <= wdata_in;
          `UFS_A_ISR_FCR: fcr_ff <= wdata_in;
          `UFS_A_MCR: mcr_ff <= wdata_in;
          `UFS_A_SPR: spr_ff <= wdata_in;
          `UFS_A_FEATURE_CONTROL_REG: feature_control_reg_ff <= wdata_in;
          `UFS_A_EFR: efr_ff <= wdata_in;
          `UFS_A_TX_FIFO_LEVEL_COUNT_TRG: tx_fifo_trigger_level_ff <= wdata_in;
          `UFS_A_RX_FIFO_LEVEL_COUNT_TRG: rx_fifo_trigger_level_ff <= wdata_in;
          `UFS_A_STOP_CHAR_FIRST: stop_char_first_out <= wdata_in;
          `UFS_A_STOP_CHAR_SECOND: stop_char_second_out <= wdata_in;
          `UFS_A_RESUME_CHAR_FIRST: resume_char_first_out <= wdata_in;
          `UFS_A_RESUME_CHAR_SECOND_XCH: resume_char_second_out <= wdata_in;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO level counters

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      tx_fifo_level_count_ff <= `UFS_RST_ZERO;
      rx_fifo_level_count_ff <= `UFS_RST_ZERO;
    end
    else
    begin
      // 256 entries fit an 8-bit count only by saturating at 0xff
      tx_fifo_level_count_ff <= ufs_count(tx_fifo_level_count_ff, tx_push_in, tx_pop_in);
      rx_fifo_level_count_ff <= ufs_count(rx_fifo_level_count_ff, rx_push_in, rx_pop_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow-control character status

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
      flow_char_status_ff <= 4'h0;
    else if (swfc_off)
      flow_char_status_ff <= 4'h0;
    else
    begin
      // Read clears, but an event in the same cycle wins over the clear of its own pair
      if (sent_resume_in || sent_stop_in)
      begin
        flow_char_status_ff[`UFS_XCH_TXON] <= sent_resume_in;
        flow_char_status_ff[`UFS_XCH_TXOFF] <= sent_stop_in && !sent_resume_in;
      end
      else if (rd_fcs)
      begin
        flow_char_status_ff[`UFS_XCH_TXON] <= 1'b0;
        flow_char_status_ff[`UFS_XCH_TXOFF] <= 1'b0;
      end
      if (got_resume_in || got_stop_in)
      begin
        flow_char_status_ff[`UFS_XCH_RXON] <= got_resume_in;
        flow_char_status_ff[`UFS_XCH_RXOFF] <= got_stop_in && !got_resume_in;
      end
      else if (rd_fcs)
      begin
        flow_char_status_ff[`UFS_XCH_RXON] <= 1'b0;
        flow_char_status_ff[`UFS_XCH_RXOFF] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem status: low nibble holds input changes, cleared by read

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      msr_lo_ff <= 4'h0;
      modem_prev_ff <= 4'h0;
      msr_armed_ff <= 1'b0;
    end
    else
    begin
      // Previous level is caught after release, so reset never flags a change
      modem_prev_ff <= modem_lvl_in;
      msr_armed_ff <= 1'b1;
      if (msr_armed_ff)
        msr_lo_ff <= (modem_prev_ff ^ modem_lvl_in)
                     | ((rd_in && addr_in == `UFS_A_MSR) ? 4'h0 : msr_lo_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and derived status

  wire tx_low = tx_fifo_level_count_ff < tx_fifo_trigger_level_ff;
  wire rx_hit = (rx_fifo_trigger_level_ff != `UFS_RST_ZERO)
                && rx_fifo_level_count_ff >= rx_fifo_trigger_level_ff;

  // Receive takes priority over transmit when both are pending
  assign isr_val = (rx_hit && ier_ff[`UFS_IER_RX]) ? `UFS_ISR_RX_FIFO_TRIGGER_LEVEL :
                   (tx_low && ier_ff[`UFS_IER_TX]) ? `UFS_ISR_TX_FIFO_TRIGGER_LEVEL :
                   `UFS_ISR_NONE;
  assign lsr_val = {1'b0, tx_fifo_level_count_ff == `UFS_RST_ZERO,
                    tx_fifo_level_count_ff == `UFS_RST_ZERO, 4'h0,
                    rx_fifo_level_count_ff != `UFS_RST_ZERO};

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
    end
    else
    begin
      tx_irq_out <= tx_low && ier_ff[`UFS_IER_TX];
      rx_irq_out <= rx_hit && ier_ff[`UFS_IER_RX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
      rdata_out <= `UFS_RST_ZERO;
    else if (!rd_in)
      rdata_out <= `UFS_RST_ZERO;
    else if (dlab && addr_in == `UFS_A_DLL)
      rdata_out <= divisor_out;
    else if (dlab && addr_in == `UFS_A_DLM)
      rdata_out <= divisor_high_out;
    else if (dlab && addr_in == `UFS_A_DLD)
      rdata_out <= divisor_fraction_out;
    else
    begin
      case (addr_in)
        `UFS_A_RHR_THR: rdata_out <= `UFS_RST_ZERO;
        `UFS_A_IER: rdata_out <= ier_ff;
        `UFS_A_ISR_FCR: rdata_out <= isr_val;
        `UFS_A_LCR: rdata_out <= lcr_ff;
        `UFS_A_MCR: rdata_out <= mcr_ff;
        `UFS_A_LSR: rdata_out <= lsr_val;
        `UFS_A_MSR: rdata_out <= {modem_lvl_in, msr_lo_ff};
        `UFS_A_SPR: rdata_out <= spr_ff;
        `UFS_A_FEATURE_CONTROL_REG: rdata_out <= feature_control_reg_ff;
        `UFS_A_EFR: rdata_out <= efr_ff;
        `UFS_A_TX_FIFO_LEVEL_COUNT_TRG: rdata_out <= tx_fifo_level_count_ff;
        `UFS_A_RX_FIFO_LEVEL_COUNT_TRG: rdata_out <= rx_fifo_level_count_ff;
        `UFS_A_RESUME_CHAR_SECOND_XCH: rdata_out <= {4'h0, flow_char_status_ff};
        default: rdata_out <= `UFS_RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      tx_out <= 1'b1;
      rts_b_out <= 1'b1;
      dtr_b_out <= 1'b1;
      infrared_tx_out <= 1'b0;
      eeprom_clock_out <= 1'b0;
      eeprom_select_out <= 1'b0;
      eeprom_data_out <= 1'b0;
    end
    else
    begin
      tx_out <= tx_serial_in;
      infrared_tx_out <= infrared_tx_in;
      // Modem control bits are active-high requests to assert the low pins
      rts_b_out <= !mcr_ff[`UFS_MCR_RTS];
      dtr_b_out <= !mcr_ff[`UFS_MCR_DTR];
      eeprom_clock_out <= 1'b0;
      eeprom_select_out <= 1'b0;
      eeprom_data_out <= 1'b0;
    end
  end

endmodule

// *** sim/test_ufs_top.sv ***
// Self-checking bench for the UART level and flow-control register block
`timescale 1ns/1ps
module test_ufs_top;
  reg mclk_in;
  reg rst_b_in;
  reg wr_in;
  reg rd_in;
  reg [3:0] addr_in;
  reg [7:0] wdata_in;
  reg [3:0] fifo;
  wire [7:0] rdata_out;
  wire [1:0] irq;
  wire [3:0] ev;
  wire [3:0] modem;
  wire line;
  wire [7:0] c0, c1, c2, c3, dv0, dv1, dv2;
  wire [6:0] pins;
  integer error_cnt, checks, i;
  localparam [43:0] ra_tab = 44'hfba98754321;
  localparam [87:0] re_tab = 88'h0000000000ff6000000100;
  ufs_serial_peer u_ufs_serial_peer (.mclk_in(mclk_in), .ev_out(ev), .line_out(line),
    .modem_out(modem));
  ufs_top u_ufs_top (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .tx_push_in(fifo[3]), .tx_pop_in(fifo[2]), .rx_push_in(fifo[1]), .rx_pop_in(fifo[0]),
    .sent_resume_in(ev[3]), .sent_stop_in(ev[2]), .got_resume_in(ev[1]), .got_stop_in(ev[0]),
    .modem_lvl_in(modem), .tx_serial_in(line), .infrared_tx_in(1'b0),
    .tx_irq_out(irq[1]), .rx_irq_out(irq[0]), .stop_char_first_out(c0),
    .stop_char_second_out(c1), .resume_char_first_out(c2), .resume_char_second_out(c3),
    .divisor_out(dv0), .divisor_high_out(dv1), .divisor_fraction_out(dv2), .tx_out(pins[6]),
    .rts_b_out(pins[5]), .dtr_b_out(pins[4]), .infrared_tx_out(pins[3]),
    .eeprom_clock_out(pins[2]), .eeprom_select_out(pins[1]), .eeprom_data_out(pins[0]));
  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////
  task chk(input string n, input [7:0] e, input [7:0] s);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %0s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  end
  endtask
  // Optional second read straight after the first, expected to read back cleared
  task rd(input [3:0] a, input [7:0] e, input two);
  begin
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= two;
    #1 chk("rdata", e, rdata_out);
    if (two)
    begin
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 chk("rdata again", 8'h00, rdata_out);
    end
  end
  endtask
  task fq(input [3:0] m, input integer n);
  begin
    @(posedge mclk_in);
    fifo <= m;
    repeat (n) @(posedge mclk_in);
    fifo <= 4'h0;
  end
  endtask
  task irq_chk(input [7:0] e);
  begin
    repeat (2) @(posedge mclk_in);
    #1 chk("irq", e, {6'h00, irq});
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    error_cnt = error_cnt + 1;
    results;
  end
  initial
  begin
    error_cnt = 0;
    checks = 0;
    rst_b_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    fifo = 4'h0;
    repeat (15) @(posedge mclk_in);
    #1 chk("pins", 8'h70, {1'b0, pins});
    chk("divisor", 8'h01, dv0);
    chk("divisor upper", 8'h00, dv1 | dv2);
    chk("chars", 8'h00, c0 | c1 | c2 | c3);
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    for (i = 0; i < 11; i = i + 1)
      rd(ra_tab[4*i +: 4], re_tab[8*i +: 8], 1'b0);
    rd(4'h6, 8'ha0, 1'b0);
    wr(4'h3, 8'h80);
    rd(4'h0, 8'h01, 1'b0);
    rd(4'h1, 8'h00, 1'b0);
    rd(4'h2, 8'h00, 1'b0);
    wr(4'h3, 8'h00);
    wr(4'hc, 8'h11);
    wr(4'hd, 8'h13);
    wr(4'he, 8'h12);
    wr(4'hf, 8'h14);
    #1 chk("chars", 8'h00, (c0 ^ 8'h11) | (c1 ^ 8'h13) | (c2 ^ 8'h12) | (c3 ^ 8'h14));
    wr(4'h4, 8'h03);
    @(posedge mclk_in);
    #1 chk("pins", 8'h40, {1'b0, pins});
    @(posedge mclk_in);
    u_ufs_serial_peer.modem_out <= 4'h5;
    rd(4'h6, 8'h5f, 1'b0);
    rd(4'h6, 8'h50, 1'b0);
    u_ufs_serial_peer.ev(4'hf);
    rd(4'hf, 8'h00, 1'b0);
    wr(4'h9, 8'h0f);
    for (i = 0; i < 4; i = i + 1)
    begin
      u_ufs_serial_peer.ev(4'h1 << i);
      rd(4'hf, 8'h01 << i, 1'b1);
    end
    u_ufs_serial_peer.ev(4'hf);
    rd(4'hf, 8'h0a, 1'b0);
    u_ufs_serial_peer.ev(4'h5);
    wr(4'h9, 8'h00);
    rd(4'hf, 8'h00, 1'b0);
    wr(4'h1, 8'h02);
    wr(4'ha, 8'h03);
    irq_chk(8'h02);
    fq(4'h8, 3);
    irq_chk(8'h00);
    rd(4'ha, 8'h03, 1'b0);
    fq(4'h4, 1);
    irq_chk(8'h02);
    rd(4'h2, 8'h02, 1'b0);
    fq(4'h8, 300);
    rd(4'ha, 8'hff, 1'b0);
    fq(4'h4, 300);
    rd(4'ha, 8'h00, 1'b0);
    wr(4'h1, 8'h03);
    wr(4'hb, 8'h04);
    fq(4'h2, 3);
    irq_chk(8'h02);
    fq(4'h2, 1);
    irq_chk(8'h03);
    rd(4'h2, 8'h04, 1'b0);
    rd(4'hb, 8'h04, 1'b0);
    fq(4'h1, 4);
    rd(4'hb, 8'h00, 1'b0);
    results;
  end
endmodule

// *** sim/ufs_serial_peer.sv ***
// Serial-side peer: flow-control events, line level and modem levels
`timescale 1ns/1ps
module ufs_serial_peer
(
  // Clock
  input wire mclk_in,
  // Events: sent resume, sent stop, got resume, got stop
  output reg [3:0] ev_out,
  // Line and modem levels
  output reg line_out,
  output reg [3:0] modem_out
);
  initial
  begin
    ev_out = 4'h0;
    line_out = 1'b1;
    modem_out = 4'ha;
  end
  // One-cycle pulse; a held event would keep winning over the read clear of the status
  task ev(input [3:0] m);
  begin
    @(posedge mclk_in);
    ev_out <= m;
    @(posedge mclk_in);
    ev_out <= 4'h0;
  end
  endtask
endmodule

// *** sim/ufs_top_properties.sv ***
// Checker for flow status reads and reset pin levels
`timescale 1ns/1ps
module ufs_top_chk
(
  // Clock, reset and register port
  input wire mclk_in,
  input wire rst_b_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  // Flow events
  input wire sent_resume_in,
  input wire sent_stop_in,
  input wire got_resume_in,
  input wire got_stop_in,
  // Pins
  input wire tx_out,
  input wire rts_b_out,
  input wire dtr_b_out,
  input wire infrared_tx_out,
  input wire eeprom_clock_out,
  input wire eeprom_select_out,
  input wire eeprom_data_out
);
  reg [3:0] sel_ff;
  wire sw_on = |sel_ff;
  wire [3:0] ev = {sent_resume_in, sent_stop_in, got_resume_in, got_stop_in};
  wire [6:0] pins = {tx_out, rts_b_out, dtr_b_out, infrared_tx_out,
                     eeprom_clock_out, eeprom_select_out, eeprom_data_out};
  // Shadow of the flow select bits, which are not visible at the ports
  always @(posedge mclk_in)
    if (!rst_b_in)
      sel_ff <= 4'h0;
    else if (wr_in && addr_in == 4'h9)
      sel_ff <= wdata_in[3:0];
  ////////////////////////////////////////
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_rd;
    rd_in && addr_in == 4'hf;
  endsequence
  sequence s_quiet_rd;
    s_rd ##0 ev == 4'h0;
  endsequence
  a_reset_pins: assert property (disable iff (1'b0) !rst_b_in |=> pins == 7'h70)
    else $error("pin levels wrong under reset");
  a_upper_zero: assert property (s_rd |=> rdata_out[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_sent_resume: assert property (sent_resume_in && sw_on ##2 s_rd |=> rdata_out[3:2] == 2'b10)
    else $error("sent resume not shown");
  a_sent_stop: assert property (ev[3:2] == 2'b01 && sw_on ##2 s_rd |=> rdata_out[3:2] == 2'b01)
    else $error("sent stop not shown");
  a_got_resume: assert property (got_resume_in && sw_on ##2 s_rd |=> rdata_out[1:0] == 2'b10)
    else $error("received resume not shown");
  a_got_stop: assert property (ev[1:0] == 2'b01 && sw_on ##2 s_rd |=> rdata_out[1:0] == 2'b01)
    else $error("received stop not shown");
  a_read_clears: assert property (s_quiet_rd ##1 s_rd |=> rdata_out[3:0] == 4'h0)
    else $error("status not cleared by read");
  a_flow_off: assert property (!sw_on ##1 (s_rd and !sw_on) |=> rdata_out == 8'h00)
    else $error("status not forced to zero");
endmodule
bind ufs_top ufs_top_chk u_ufs_top_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .sent_resume_in(sent_resume_in), .sent_stop_in(sent_stop_in),
  .got_resume_in(got_resume_in), .got_stop_in(got_stop_in), .tx_out(tx_out),
  .rts_b_out(rts_b_out), .dtr_b_out(dtr_b_out), .infrared_tx_out(infrared_tx_out),
  .eeprom_clock_out(eeprom_clock_out), .eeprom_select_out(eeprom_select_out),
  .eeprom_data_out(eeprom_data_out));
